// ### hw/ccs_seq.sv
/*
 * charge-cycle sequencer: qualification, conditioning, fast charge with
 * chemistry detection, nickel top-off and maintenance, lithium cv phase.
 * assumes threshold flags come from analog comparators already sampled on
 * hclk; timer period is set by software in seconds over ahb-lite.
 */
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// RL1: new cycle on power, insert, wake, lithium depletion
// RL2: cycle starts with voltage and temperature qualification
// RL3: cell below low threshold enters conditioning
// RL4: conditioning pulses switch once per second
// RL5: indicator blinks 1 Hz while qualification pending
// RL6: leave conditioning only when voltage and temperature ok
// RL7: timer stopped during conditioning
// RL8: reaching max cell voltage early means lithium
// RL9: indicator held low during fast charge
// RL10: nickel: fast, optional top-off, then maintenance
// RL11: lithium cc until max voltage, then current termination
// RL12: lithium cv ends on taper current or timeout
// RL13: lithium restarts below recharge threshold
// RL14: no maintenance for lithium after termination
// RL15: nickel one period, lithium two periods total
// RL16: peak-drop disabled for period/32 after start
// RL17: period equals resistance times capacitance times 35988; here software writes the period register directly
// RL18: cold fault pauses timer, conditions, then resumes
// RL19: cv entry adds one full period to timer
// RL20: nickel top-off restarts timer after fast charge
// RL21: cc phase watches time, temperature and voltage
// RL22: maintenance pulse rate about one per second
// RL23: switch high passes current, low blocks it
// RL24: threshold comparisons arrive as synchronous flags
// RL25: timer is pausable counter on prescaled tick
module ccs_seq #(
   parameter int unsigned TICK_CYC = ccs_pkg::TICK_CYCLES
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        pack_present,
   input  wire logic        sleep_req,
   input  wire logic        cell_below_low,      // RL24
   input  wire logic        cell_at_max,
   input  wire logic        cell_below_recharge,
   input  wire logic        temp_cold_fault,
   input  wire logic        temp_hot_fault,
   input  wire logic        current_below_taper,
   input  wire logic        peak_drop_detect,
   output logic             charge_switch_out,
   output logic             status_indicator_n
);
   typedef struct packed {
      ccs_pkg::ccs_state_t st;
      ccs_pkg::ccs_state_t resume_st;
      logic        lithium;
      logic        topoff_en;
      logic        restart;
      logic [31:0] period;
      logic [31:0] trickle_cyc;
      logic [31:0] pulse_cnt;
      logic        pulse_on;
      logic        blink;
      logic        present_q;
      logic        sleep_q;
      logic        wr_pend;
      logic        rd_pend;
      logic [7:0]  addr;
      logic [31:0] rdata;
      logic        sw;
      logic        led_n;
   } ccs_seq_t;
   ccs_seq_t s_q, s_d;

   logic tick, half;
   ccs_tick_if ti ();

   ccs_prescaler #(.TICK_CYC(TICK_CYC)) u_pre (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tick    (tick),
      .half    (half)
   );
   ccs_timer u_tmr (
      .hclk    (hclk),
      .hresetn (hresetn),
      .t       (ti.tmr)
   );

   function automatic logic temp_ok(input logic cold, input logic hot);
      temp_ok = !cold && !hot;
   endfunction

   wire logic start_evt = (pack_present && !s_q.present_q)        // RL1
                        || (!sleep_req && s_q.sleep_q) || s_q.restart;
   wire logic in_cond  = (s_q.st == ccs_pkg::ST_COND);
   wire logic in_fast  = (s_q.st == ccs_pkg::ST_FAST_CC) || (s_q.st == ccs_pkg::ST_FAST_CV);

   assign ti.tick = tick;
   assign ti.period = s_q.period;
   assign ti.run = (s_q.st == ccs_pkg::ST_FAST_CC) || (s_q.st == ccs_pkg::ST_FAST_CV)
                 || (s_q.st == ccs_pkg::ST_TOPOFF);                // RL7 RL25
   assign ti.clear = start_evt
                   || (s_q.st == ccs_pkg::ST_FAST_CC && s_d.st == ccs_pkg::ST_TOPOFF); // RL20
   assign ti.add_period = (s_q.st == ccs_pkg::ST_FAST_CC)
                        && (s_d.st == ccs_pkg::ST_FAST_CV);         // RL19

   always_comb
   begin
      s_d = s_q;
      s_d.present_q = pack_present;
      s_d.sleep_q   = sleep_req;
      s_d.restart   = 1'b0;
      if (half || tick)
         s_d.blink = !s_q.blink;

      // trickle pulse: once per tick, width from register
      if (tick)
      begin
         s_d.pulse_cnt = s_q.trickle_cyc;                           // RL22
         s_d.pulse_on  = 1'b1;
      end
      else if (s_q.pulse_cnt != 32'h0)
         s_d.pulse_cnt = s_q.pulse_cnt - 32'h1;
      else
         s_d.pulse_on = 1'b0;

      case (s_q.st)
         ccs_pkg::ST_IDLE:
            if (pack_present && !sleep_req)
               s_d.st = ccs_pkg::ST_QUAL;
         ccs_pkg::ST_QUAL:                                           // RL2
         begin
            s_d.lithium = 1'b0;
            if (cell_below_low || !temp_ok(temp_cold_fault, temp_hot_fault))
            begin
               s_d.st = ccs_pkg::ST_COND;                            // RL3
               s_d.resume_st = ccs_pkg::ST_FAST_CC;
            end
            else
               s_d.st = ccs_pkg::ST_FAST_CC;
         end
         ccs_pkg::ST_COND:                                           // RL6
            if (!cell_below_low && temp_ok(temp_cold_fault, temp_hot_fault))
               s_d.st = s_q.resume_st;                               // RL18
         ccs_pkg::ST_FAST_CC:                                        // RL21
            if (temp_cold_fault)
            begin
               s_d.st = ccs_pkg::ST_COND;                            // RL18
               s_d.resume_st = ccs_pkg::ST_FAST_CC;
            end
            else if (cell_at_max)
            begin
               s_d.lithium = 1'b1;                                   // RL8
               s_d.st = ccs_pkg::ST_FAST_CV;                         // RL11
            end
            else if (ti.expired || (peak_drop_detect && !ti.holdoff)) // RL16 RL15
               s_d.st = s_q.topoff_en ? ccs_pkg::ST_TOPOFF : ccs_pkg::ST_MAINT; // RL10
         ccs_pkg::ST_FAST_CV:
            if (temp_cold_fault)
            begin
               s_d.st = ccs_pkg::ST_COND;
               s_d.resume_st = ccs_pkg::ST_FAST_CV;
            end
            else if (current_below_taper || ti.expired)               // RL12 RL14
               s_d.st = ccs_pkg::ST_DONE;
         ccs_pkg::ST_TOPOFF:
            if (ti.expired || cell_at_max || temp_hot_fault)
               s_d.st = ccs_pkg::ST_MAINT;
         ccs_pkg::ST_MAINT:
            if (cell_at_max)                                         // RL10
               s_d.st = ccs_pkg::ST_SUSP;
         ccs_pkg::ST_SUSP:
            if (!cell_at_max)
               s_d.st = ccs_pkg::ST_MAINT;
         ccs_pkg::ST_DONE:
            if (cell_below_recharge)                                 // RL13
               s_d.restart = 1'b1;
         default:
            s_d.st = ccs_pkg::ST_IDLE;
      endcase
      if (start_evt)
         s_d.st = ccs_pkg::ST_QUAL;                                  // RL1
      if (!pack_present || sleep_req)
         s_d.st = ccs_pkg::ST_IDLE;

      case (s_d.st)
         ccs_pkg::ST_FAST_CC, ccs_pkg::ST_FAST_CV:
            s_d.sw = 1'b1;                                           // RL23
         ccs_pkg::ST_COND, ccs_pkg::ST_MAINT:
            s_d.sw = s_d.pulse_on;                                   // RL4
         ccs_pkg::ST_TOPOFF:
            s_d.sw = s_d.pulse_on && (s_q.pulse_cnt > (s_q.trickle_cyc >> 1));
         default:
            s_d.sw = 1'b0;
      endcase
      case (s_d.st)
         ccs_pkg::ST_FAST_CC, ccs_pkg::ST_FAST_CV:
            s_d.led_n = 1'b0;                                        // RL9
         ccs_pkg::ST_QUAL, ccs_pkg::ST_COND:
            s_d.led_n = s_d.blink;                                   // RL5
         default:
            s_d.led_n = 1'b1;
      endcase

      // ahb-lite slave, zero wait states
      if (s_q.wr_pend)
      begin
         case (s_q.addr)
            ccs_pkg::ADDR_CTRL:
            begin
               s_d.topoff_en = hwdata[ccs_pkg::CTRL_TOPOFF_BIT];
               if (hwdata[ccs_pkg::CTRL_RESTART_BIT])
                  s_d.restart = 1'b1;
            end
            ccs_pkg::ADDR_PERIOD:  s_d.period = hwdata;              // RL17
            ccs_pkg::ADDR_TRICKLE: s_d.trickle_cyc = hwdata;
            default: ;
         endcase
      end
      s_d.wr_pend = hsel && hready && htrans[1] && hwrite;
      s_d.rd_pend = hsel && hready && htrans[1] && !hwrite;
      if (hsel && hready && htrans[1])
         s_d.addr = haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite)
      begin
         case (haddr[7:0])
            ccs_pkg::ADDR_CTRL:    s_d.rdata = {30'h0, 1'b0, s_q.topoff_en};
            ccs_pkg::ADDR_PERIOD:  s_d.rdata = s_q.period;
            ccs_pkg::ADDR_TRICKLE: s_d.rdata = s_q.trickle_cyc;
            ccs_pkg::ADDR_STATUS:  s_d.rdata = {22'h0, s_q.lithium, s_q.st};
            ccs_pkg::ADDR_TIMER:   s_d.rdata = ti.remaining;
            default:               s_d.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_q             <= '0;
         s_q.st          <= ccs_pkg::ST_IDLE;
         s_q.resume_st   <= ccs_pkg::ST_FAST_CC;
         s_q.period      <= ccs_pkg::PERIOD_RESET;
         s_q.trickle_cyc <= ccs_pkg::TRICKLE_RESET;
         s_q.led_n       <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   assign hrdata             = s_q.rdata;
   assign hreadyout          = 1'b1;
   assign hresp              = 1'b0;
   assign charge_switch_out  = s_q.sw;
   assign status_indicator_n = s_q.led_n;

   // properties read registered state, so an effect shows one edge after its cause
   cond_no_timer_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL7
      in_cond |-> !ti.run) else $error("timer runs in conditioning");
   fast_led_low_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL9
      in_fast |-> !status_indicator_n)
      else $error("indicator not low in fast charge");
   low_cell_cond_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL3
      (s_q.st == ccs_pkg::ST_QUAL && cell_below_low && pack_present && !sleep_req
       && !start_evt) |=> in_cond) else $error("low cell not conditioned");
   li_detect_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL8
      (s_q.st == ccs_pkg::ST_FAST_CC && cell_at_max && !temp_cold_fault && pack_present
       && !sleep_req && !start_evt) |=> s_q.lithium && s_q.st == ccs_pkg::ST_FAST_CV)
      else $error("lithium not detected");
   cv_add_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL19
      ti.add_period |=> ti.remaining == $past(ti.remaining) + $past(s_q.period))
      else $error("period not added on cv entry");
   cv_end_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL12
      (s_q.st == ccs_pkg::ST_FAST_CV && current_below_taper && !temp_cold_fault
       && pack_present && !sleep_req && !start_evt) |=> s_q.st == ccs_pkg::ST_DONE)
      else $error("cv charge not ended");
   li_no_maint_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL14
      s_q.st == ccs_pkg::ST_DONE |-> !charge_switch_out) else $error("lithium maintained");
   cold_pause_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL18
      (in_fast && temp_cold_fault && pack_present && !sleep_req && !start_evt)
      |=> in_cond ##1 (!in_cond || $stable(ti.remaining)))
      else $error("cold fault not paused");

   fast_switch_on_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL23
      in_fast |-> charge_switch_out) else $error("switch off in fast charge");
   pending_blink_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL5
      (s_q.st == ccs_pkg::ST_QUAL || in_cond) |-> status_indicator_n == s_q.blink)
      else $error("indicator not blinking while pending");
   insert_qual_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
      (pack_present && !s_q.present_q && !sleep_req) |=> s_q.st == ccs_pkg::ST_QUAL)
      else $error("insertion did not start a cycle");
   qual_fast_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL2
      (s_q.st == ccs_pkg::ST_QUAL && !cell_below_low && !temp_cold_fault && !temp_hot_fault
       && pack_present && !sleep_req && !start_evt) |=> s_q.st == ccs_pkg::ST_FAST_CC)
      else $error("qualified pack not fast charged");
   cond_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL6
      (in_cond && (cell_below_low || temp_cold_fault || temp_hot_fault) && pack_present
       && !sleep_req && !start_evt) |=> in_cond)
      else $error("conditioning left too early");
   holdoff_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL16
      (s_q.st == ccs_pkg::ST_FAST_CC && ti.holdoff && !ti.expired && !cell_at_max
       && !temp_cold_fault && pack_present && !sleep_req && !start_evt)
      |=> s_q.st == ccs_pkg::ST_FAST_CC)
      else $error("peak drop acted inside hold-off");
   topoff_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL20
      (s_q.st == ccs_pkg::ST_FAST_CC && s_d.st == ccs_pkg::ST_TOPOFF)
      |=> ti.remaining == $past(s_q.period))
      else $error("timer not reset for top-off");
   cc_timeout_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL15
      (s_q.st == ccs_pkg::ST_FAST_CC && ti.expired && !cell_at_max && !temp_cold_fault
       && pack_present && !sleep_req && !start_evt)
      |=> (s_q.st == ccs_pkg::ST_TOPOFF || s_q.st == ccs_pkg::ST_MAINT))
      else $error("fast charge outlived its period");
   cv_timeout_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL12
      (s_q.st == ccs_pkg::ST_FAST_CV && ti.expired && !temp_cold_fault && pack_present
       && !sleep_req && !start_evt) |=> s_q.st == ccs_pkg::ST_DONE)
      else $error("cv charge outlived its timer");
   maint_stop_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL10
      (s_q.st == ccs_pkg::ST_MAINT && cell_at_max && pack_present && !sleep_req
       && !start_evt) |=> s_q.st == ccs_pkg::ST_SUSP)
      else $error("maintenance not stopped at max cell");
   susp_off_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL10
      s_q.st == ccs_pkg::ST_SUSP |-> !charge_switch_out)
      else $error("switch on while suspended");
   recharge_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL13
      (s_q.st == ccs_pkg::ST_DONE && cell_below_recharge) |=> s_q.restart)
      else $error("recharge not requested");
   restart_qual_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL13
      (s_q.restart && pack_present && !sleep_req) |=> s_q.st == ccs_pkg::ST_QUAL)
      else $error("restart did not requalify");
   cond_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
      in_cond |-> charge_switch_out == s_q.pulse_on) else $error("conditioning pulse wrong");
endmodule

// ### hw/ccs_pkg.sv
/*
 * constants and types shared by the charge-cycle sequencer files.
 * assumes a single 250 MHz clock; all times but the period, kept in seconds, become cycle counts here.
 */
package ccs_pkg;
   localparam int unsigned CLK_HZ          = 250_000_000;
   localparam real         TICK_PERIOD_S   = 1.0;
   localparam int unsigned TICK_CYCLES     = int'(TICK_PERIOD_S * CLK_HZ);
   localparam real         BLINK_HZ        = 1.0;
   localparam int unsigned BLINK_HALF_CYC  = int'(CLK_HZ / (2.0 * BLINK_HZ));
   localparam int unsigned MTO_FACTOR      = 35988;
   localparam int unsigned HOLDOFF_DIV     = 32;
   localparam int unsigned TOPOFF_PULSE_DIV = 16;
   localparam int unsigned TIMER_W         = 32;

   // bus map, one word each
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_PERIOD  = 8'h04;
   localparam logic [7:0] ADDR_TRICKLE = 8'h08;
   localparam logic [7:0] ADDR_STATUS  = 8'h0c;
   localparam logic [7:0] ADDR_TIMER   = 8'h10;

   localparam int unsigned CTRL_TOPOFF_BIT  = 0;
   localparam int unsigned CTRL_RESTART_BIT = 1;
   localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
   localparam logic [31:0] PERIOD_RESET     = 32'h0000_0e10;
   localparam logic [31:0] TRICKLE_RESET    = 32'h00f0_0000;

   typedef enum logic [8:0] {
      ST_QUAL    = 9'h001,
      ST_COND    = 9'h002,
      ST_FAST_CC = 9'h004,
      ST_FAST_CV = 9'h008,
      ST_TOPOFF  = 9'h010,
      ST_MAINT   = 9'h020,
      ST_DONE    = 9'h040,
      ST_SUSP    = 9'h080,
      ST_IDLE    = 9'h100
   } ccs_state_t;
endpackage

// ### hw/ccs_tick_if.sv
/*
 * carrier for the timer's tick and control between sequencer and counter.
 * assumes one clock domain.
 */
`timescale 1ns/1ps
interface ccs_tick_if;
   logic        tick;
   logic        run;
   logic        clear;
   logic        add_period;
   logic [31:0] period;
   logic [31:0] remaining;
   logic        expired;
   logic        holdoff;
   modport seq (output run, clear, add_period, period, input tick, remaining, expired, holdoff);
   modport tmr (input run, clear, add_period, period, tick, output remaining, expired, holdoff);
endinterface

// ### hw/ccs_prescaler.sv
/*
 * one-second tick divider for the charge timer and indicator blink.
 * assumes hclk at the package rate.
 */
`timescale 1ns/1ps
module ccs_prescaler #(
   parameter int unsigned TICK_CYC = ccs_pkg::TICK_CYCLES
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   output logic      tick,
   output logic      half
);
   typedef struct packed {
      logic [31:0] cnt;
      logic        tick;
      logic        half;
   } ccs_pre_t;
   ccs_pre_t s_q, s_d;

   always_comb
   begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      s_d.half = 1'b0;
      if (s_q.cnt >= 32'(TICK_CYC - 1))
      begin
         s_d.cnt  = 32'h0;
         s_d.tick = 1'b1;
      end
      else
      begin
         s_d.cnt = s_q.cnt + 32'h1;
      end
      if (s_q.cnt == 32'(TICK_CYC / 2 - 1))
         s_d.half = 1'b1;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign tick = s_q.tick;
   assign half = s_q.half;
endmodule

// ### hw/ccs_timer.sv
/*
 * pausable, resettable charge timer counting down in prescaled ticks.
 * assumes tick is a one-cycle pulse; period is in seconds.
 */
`timescale 1ns/1ps
module ccs_timer (
   input wire logic hclk,
   input wire logic hresetn,
   ccs_tick_if.tmr  t
);
   typedef struct packed {
      logic [31:0] rem;
      logic [31:0] elapsed;
   } ccs_tmr_t;
   ccs_tmr_t s_q, s_d;

   always_comb
   begin
      s_d = s_q;
      if (t.clear)
      begin
         s_d.rem     = t.period;
         s_d.elapsed = 32'h0;
      end
      else if (t.add_period)
         s_d.rem = s_q.rem + t.period;
      else if (t.run && t.tick && s_q.rem != 32'h0)
      begin
         s_d.rem     = s_q.rem - 32'h1;
         s_d.elapsed = s_q.elapsed + 32'h1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign t.remaining = s_q.rem;
   assign t.expired   = (s_q.rem == 32'h0);
   // peak-drop stays off for the first period/32 of fast charge
   assign t.holdoff   = (s_q.elapsed < (t.period / ccs_pkg::HOLDOFF_DIV));
endmodule

// ### dv/ccs_pack_model.sv
/*
 * battery pack model: turns the commanded cell level, temperature band,
 * taper and peak-drop events into the sequencer's comparator flags.
 * assumes the bench commands the levels; flags change only on hclk.
 */
`timescale 1ns/1ps
module ccs_pack_model #(
   parameter int LOW_MV = 950,
   parameter int MAX_MV = 2000,
   parameter int RCH_MV = 1900
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic [11:0] cell_mv,
   input  wire logic [1:0]  temp_st,
   input  wire logic        taper,
   input  wire logic        pdrop,
   output logic      [6:0]  flags
);
   logic [6:0] flags_q;
   logic [6:0] flags_d;

   // temp_st: 1 cold, 2 hot, else in band
   always_comb
   begin
      flags_d[0] = cell_mv < LOW_MV;
      flags_d[1] = cell_mv >= MAX_MV;
      flags_d[2] = cell_mv < RCH_MV;
      flags_d[3] = temp_st == 2'h1;
      flags_d[4] = temp_st == 2'h2;
      flags_d[5] = taper;
      flags_d[6] = pdrop;
   end

   // registered, as a real comparator sampler would be
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         flags_q <= 7'h00;
      else
         flags_q <= flags_d;
   end
   assign flags = flags_q;
endmodule

// ### dv/tb.sv
/*
 * self-checking bench for the charge-cycle sequencer.
 * assumes the pack model for flags and a 100-cycle second.
 */
`timescale 1ns/1ps
module tb;
   localparam int          TICK = 100;
   localparam logic [31:0] PER  = 32'h0000_0040;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        pack_present;
   logic        sleep_req;
   logic        csw;
   logic        ind_n;
   logic [6:0]  fl;
   logic [11:0] cell_mv;
   logic [1:0]  temp_st;
   logic        taper;
   logic        pdrop;
   logic [31:0] rd;
   logic [31:0] t1;
   int          num_errors;
   int          n_tests;
   int          cyc;
   int          up;
   int          hi;
   int          tg;

   ccs_seq #(.TICK_CYC(TICK)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .pack_present(pack_present), .sleep_req(sleep_req),
      .cell_below_low(fl[0]), .cell_at_max(fl[1]), .cell_below_recharge(fl[2]),
      .temp_cold_fault(fl[3]), .temp_hot_fault(fl[4]),
      .current_below_taper(fl[5]), .peak_drop_detect(fl[6]),
      .charge_switch_out(csw), .status_indicator_n(ind_n));

   ccs_pack_model pack (
      .hclk(hclk), .hresetn(hresetn), .cell_mv(cell_mv), .temp_st(temp_st),
      .taper(taper), .pdrop(pdrop), .flags(fl));

   initial
   begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   // longest test is the top-off run of 64 ticks
   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         num_errors++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wst(input string nm, input logic [8:0] s);
      for (int i = 0; i < 3000; i++)
      begin
         bus(1'b0, ccs_pkg::ADDR_STATUS, 32'h0);
         if (rd[8:0] === s)
            break;
      end
      chk(nm, {23'h0, s}, {23'h0, rd[8:0]});
   endtask

   // counts switch rises, switch-high cycles and lamp toggles
   task automatic watch(input int n);
      logic ps;
      logic pi;
      up = 0;
      hi = 0;
      tg = 0;
      ps = csw;
      pi = ind_n;
      repeat (n)
      begin
         @(posedge hclk);
         #1;
         up += int'(csw === 1'b1 && ps !== 1'b1);
         hi += int'(csw === 1'b1);
         tg += int'(ind_n !== pi);
         ps = csw;
         pi = ind_n;
      end
   endtask

   task automatic t_reset();
      logic [7:0]  a [5] = '{ccs_pkg::ADDR_CTRL, ccs_pkg::ADDR_PERIOD,
                             ccs_pkg::ADDR_TRICKLE, ccs_pkg::ADDR_STATUS, 8'h20};
      logic [31:0] v [5] = '{ccs_pkg::CTRL_RESET, ccs_pkg::PERIOD_RESET,
                             ccs_pkg::TRICKLE_RESET, 32'h0000_0100, 32'h0};
      chk("idle switch", 32'h0, csw);
      chk("idle lamp", 32'h1, ind_n);
      chk("okay resp", 32'h0, hresp);
      bus(1'b1, 8'h20, 32'h5a5a_5a5a);
      for (int i = 0; i < 5; i++)
      begin
         bus(1'b0, a[i], 32'h0);
         chk("reg reset", v[i], rd);
      end
      bus(1'b1, ccs_pkg::ADDR_PERIOD, PER);
      bus(1'b1, ccs_pkg::ADDR_TRICKLE, 32'h0000_000a);
      bus(1'b0, ccs_pkg::ADDR_PERIOD, 32'h0);
      chk("period", PER, rd);
      $display("test reset done");
   endtask

   task automatic t_cond();
      cell_mv <= 12'h1f4;
      pack_present <= 1'b1;
      wst("insert to cond", ccs_pkg::ST_COND);
      watch(300);
      chk("cond pulses", 32'h3, up);
      chk("pending blink", 32'h6, tg);
      bus(1'b0, ccs_pkg::ADDR_TIMER, 32'h0);
      t1 = rd;
      repeat (300) @(posedge hclk);
      bus(1'b0, ccs_pkg::ADDR_TIMER, 32'h0);
      chk("cond timer", t1, rd);
      cell_mv <= 12'h5dc;
      temp_st <= 2'h2;
      repeat (200) @(posedge hclk);
      wst("hot holds", ccs_pkg::ST_COND);
      temp_st <= 2'h0;
      wst("cond to fast", ccs_pkg::ST_FAST_CC);
      $display("test cond done");
   endtask

   task automatic t_fast();
      watch(100);
      chk("fast switch", 32'h64, hi);
      chk("fast lamp", 32'h0, tg);
      chk("lamp lit", 32'h0, ind_n);
      bus(1'b0, ccs_pkg::ADDR_TIMER, 32'h0);
      t1 = rd;
      repeat (197) @(posedge hclk);
      bus(1'b0, ccs_pkg::ADDR_TIMER, 32'h0);
      chk("timer runs", 32'h2, t1 - rd);
      t1 = rd;
      temp_st <= 2'h1;
      wst("cold pause", ccs_pkg::ST_COND);
      watch(300);
      chk("cold blink", 32'h6, tg);
      temp_st <= 2'h0;
      wst("cold resume", ccs_pkg::ST_FAST_CC);
      bus(1'b0, ccs_pkg::ADDR_TIMER, 32'h0);
      chk("timer kept", 32'h1, t1 - rd <= 32'h1);
      $display("test fast done");
   endtask

   task automatic t_li();
      bus(1'b0, ccs_pkg::ADDR_TIMER, 32'h0);
      t1 = rd;
      cell_mv <= 12'h7d0;
      wst("cc to cv", ccs_pkg::ST_FAST_CV);
      chk("lithium", 32'h1, rd[9]);
      bus(1'b0, ccs_pkg::ADDR_TIMER, 32'h0);
      chk("cv extend", 32'h1, rd + 1 >= t1 + PER && rd <= t1 + PER);
      taper <= 1'b1;
      wst("taper end", ccs_pkg::ST_DONE);
      watch(300);
      chk("no upkeep", 32'h0, hi);
      taper <= 1'b0;
      cell_mv <= 12'h708;
      wst("recharge", ccs_pkg::ST_FAST_CC);
      $display("test lithium done");
   endtask

   task automatic t_ni();
      bus(1'b1, ccs_pkg::ADDR_CTRL, 32'h0000_0001);
      sleep_req <= 1'b1;
      cell_mv <= 12'h5dc;
      repeat (100) @(posedge hclk);
      sleep_req <= 1'b0;
      pdrop <= 1'b1;
      wst("wake start", ccs_pkg::ST_FAST_CC);
      repeat (50) @(posedge hclk);
      wst("holdoff", ccs_pkg::ST_FAST_CC);
      wst("peak to topoff", ccs_pkg::ST_TOPOFF);
      chk("nickel", 32'h0, rd[9]);
      bus(1'b0, ccs_pkg::ADDR_TIMER, 32'h0);
      chk("topoff timer", 32'h1, rd + 2 >= PER);
      pdrop <= 1'b0;
      wst("maintain", ccs_pkg::ST_MAINT);
      watch(300);
      chk("upkeep pulses", 32'h3, up);
      $display("test nickel done");
   endtask

   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      pack_present = 1'b0;
      sleep_req = 1'b0;
      cell_mv = 12'h000;
      temp_st = 2'h0;
      taper = 1'b0;
      pdrop = 1'b0;
      num_errors = 0;
      n_tests = 0;
      cyc = 0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_cond();
      t_fast();
      t_li();
      t_ni();
      wrap_up();
   end
endmodule
